/* core/spr_pkg.sv */
/*
 * Constants for the sensor parallel register load block: bus layout,
 * mode register selects, field positions, reset values and codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spr_pkg;

    localparam int SPR_BUS_W = 10;
    localparam int SPR_REG_W = 8;
    localparam int SPR_NUM_REGS = 4;

    // Upper bus bits select the mode register
    localparam int SPR_SEL_HI = 9;
    localparam int SPR_SEL_LO = 8;

    localparam logic [1:0] SPR_SEL_SCAN = 2'h0;
    localparam logic [1:0] SPR_SEL_AMP = 2'h1;
    localparam logic [1:0] SPR_SEL_BLACK = 2'h2;
    localparam logic [1:0] SPR_SEL_COLOFS = 2'h3;

    localparam logic [SPR_REG_W-1:0] SPR_MODE_RST = 8'h00;
    localparam logic [SPR_BUS_W-1:0] SPR_COORD_RST = 10'h000;

    // Scan mode control fields
    localparam int SPR_ENDSEL_HI = 6;
    localparam int SPR_ENDSEL_LO = 5;
    localparam int SPR_AIN_HI = 4;
    localparam int SPR_AIN_LO = 2;
    localparam int SPR_NDR_BIT = 1;
    localparam int SPR_STBY_BIT = 0;

    // Amplifier setting fields
    localparam int SPR_AOFS_HI = 7;
    localparam int SPR_AOFS_LO = 2;
    localparam int SPR_GAIN_HI = 1;
    localparam int SPR_GAIN_LO = 0;

    // Black level: codes with this bit set lie below mid-scale
    localparam int SPR_BLACK_SIGN_BIT = 7;

    typedef enum logic [1:0] {
        SPR_END_LINE_READ = 2'b00,
        SPR_END_LINE_RESET = 2'b01,
        SPR_END_PIXEL_A = 2'b10,
        SPR_END_PIXEL_B = 2'b11
    } spr_endsel_t;

    typedef enum logic [2:0] {
        SPR_AIN_PIXEL = 3'b000,
        SPR_AIN_TEMP = 3'b001,
        SPR_AIN_UNUSED0 = 3'b010,
        SPR_AIN_UNUSED1 = 3'b011,
        SPR_AIN_AUX1 = 3'b100,
        SPR_AIN_AUX2 = 3'b101,
        SPR_AIN_AUX3 = 3'b110,
        SPR_AIN_AUX4 = 3'b111
    } spr_ain_t;

    localparam int SPR_AIN_OUTS = 6;

endpackage

/* core/spr_mode_if.sv */
/*
 * Carrier between the top and the mode register file: one write port
 * plus a level clear, and the four stored registers.
 * Assumes spr_pkg is compiled first.
 */
`timescale 1ns/10ps
interface spr_mode_if;
    import spr_pkg::*;

    logic wr_pulse;
    logic [1:0] wr_sel;
    logic [SPR_REG_W-1:0] wr_data;
    logic clr;
    logic [SPR_REG_W-1:0] regs [SPR_NUM_REGS];

    modport store (
        input wr_pulse,
        input wr_sel,
        input wr_data,
        input clr,
        output regs
    );

    modport user (
        output wr_pulse,
        output wr_sel,
        output wr_data,
        output clr,
        input regs
    );
endinterface

/* core/spr_mode_regs.sv */
/*
 * Four 8-bit mode registers written one at a time on a pulse.
 * Assumes the pulse is one clk_sys cycle wide per strobe rising edge.
 */
`timescale 1ns/10ps
module spr_mode_regs
    import spr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    spr_mode_if.store mif
);

    genvar gi;
    generate
        for (gi = 0; gi < SPR_NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk_sys) begin
                if (!resetn || mif.clr) begin
                    mif.regs[gi] <= SPR_MODE_RST;
                end else if (mif.wr_pulse && mif.wr_sel == 2'(gi)) begin
                    mif.regs[gi] <= mif.wr_data;
                end
            end
        end
    endgenerate

endmodule

/* core/spr_coord_latch.sv */
/*
 * One window start coordinate, following the bus while its strobe is
 * high and holding once it drops.
 * Assumes bus and strobe are synchronous to clk_sys.
 */
`timescale 1ns/10ps
module spr_coord_latch
    import spr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic load_strobe,
    input wire logic [SPR_BUS_W-1:0] bus_in,
    output logic [SPR_BUS_W-1:0] coord_r
);

    // Not cleared by mode_reset_n, only by the system reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            coord_r <= SPR_COORD_RST;
        end else if (load_strobe) begin
            coord_r <= bus_in;
        end
    end

endmodule

/* core/spr_top.sv */
/*
 * Parallel programming port of the image sensor: two window start
 * coordinates, four mode registers and their decoded controls.
 * Assumes bus and strobes are synchronous to clk_sys and stable while
 * a strobe is high; pointer last-stage inputs come from the scan logic.
 */
`timescale 1ns/10ps
module spr_top
    import spr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [SPR_BUS_W-1:0] prog_bus,
    input wire logic column_start_strobe,
    input wire logic line_start_strobe,
    input wire logic mode_load_strobe,
    input wire logic mode_reset_n,
    input wire logic line_read_pointer_last,
    input wire logic line_reset_pointer_last,
    input wire logic pixel_read_pointer_last,
    output logic [SPR_BUS_W-1:0] line_start_coord,
    output logic [SPR_BUS_W-1:0] line_read_pointer_start,
    output logic [SPR_BUS_W-1:0] line_reset_pointer_start,
    output logic [SPR_BUS_W-1:0] column_start_coord,
    output logic [SPR_BUS_W-1:0] pixel_read_pointer_start,
    output logic [SPR_REG_W-1:0] scan_mode_control,
    output logic [SPR_REG_W-1:0] output_amp_setting,
    output logic [SPR_REG_W-1:0] ndr_black_level,
    output logic [SPR_REG_W-1:0] column_offset_trim,
    output logic end_of_scan_r,
    output logic [SPR_AIN_OUTS-1:0] analog_route_r,
    output logic readout_mode_bit,
    output logic column_bias_en_r,
    output logic amp_en_r,
    output logic out_buffer_en_r,
    output logic offset_dac_en_r,
    output logic [5:0] amp_offset_code,
    output logic [1:0] amp_gain_code,
    output logic [3:0] amp_gain_factor_r,
    output logic black_level_apply_r,
    output logic signed [SPR_REG_W:0] black_level_steps_r,
    output logic column_offset_apply_r
);

    ////////////////////////////////////////////////////////////////////
    // Window start coordinates

    logic [SPR_BUS_W-1:0] line_coord_r;
    logic [SPR_BUS_W-1:0] col_coord_r;

    spr_coord_latch u_line (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load_strobe(line_start_strobe),
        .bus_in(prog_bus),
        .coord_r(line_coord_r)
    );

    spr_coord_latch u_col (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load_strobe(column_start_strobe),
        .bus_in(prog_bus),
        .coord_r(col_coord_r)
    );

    assign line_start_coord = line_coord_r;
    assign line_read_pointer_start = line_coord_r;
    assign line_reset_pointer_start = line_coord_r;
    assign column_start_coord = col_coord_r;
    assign pixel_read_pointer_start = col_coord_r;

    ////////////////////////////////////////////////////////////////////
    // Mode register load

    logic mode_strobe_d_r;
    logic mode_rise;
    spr_mode_if mif ();

    // Reset low so a strobe already high at release counts as an edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mode_strobe_d_r <= 1'b0;
        end else begin
            mode_strobe_d_r <= mode_load_strobe;
        end
    end

    assign mode_rise = mode_load_strobe && !mode_strobe_d_r;
    assign mif.wr_pulse = mode_rise;
    assign mif.wr_sel = prog_bus[SPR_SEL_HI:SPR_SEL_LO];
    assign mif.wr_data = prog_bus[SPR_REG_W-1:0];
    assign mif.clr = !mode_reset_n;

    spr_mode_regs u_regs (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .mif(mif)
    );

    assign scan_mode_control = mif.regs[SPR_SEL_SCAN];
    assign output_amp_setting = mif.regs[SPR_SEL_AMP];
    assign ndr_black_level = mif.regs[SPR_SEL_BLACK];
    assign column_offset_trim = mif.regs[SPR_SEL_COLOFS];

    ////////////////////////////////////////////////////////////////////
    // Scan mode decode

    spr_endsel_t end_sel;
    spr_ain_t ain_sel;
    logic standby;

    assign end_sel = spr_endsel_t'(scan_mode_control[SPR_ENDSEL_HI:SPR_ENDSEL_LO]);
    assign ain_sel = spr_ain_t'(scan_mode_control[SPR_AIN_HI:SPR_AIN_LO]);
    assign readout_mode_bit = scan_mode_control[SPR_NDR_BIT];
    assign standby = scan_mode_control[SPR_STBY_BIT];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            end_of_scan_r <= 1'b0;
        end else begin
            case (end_sel)
                SPR_END_LINE_READ: end_of_scan_r <= line_read_pointer_last;
                SPR_END_LINE_RESET: end_of_scan_r <= line_reset_pointer_last;
                SPR_END_PIXEL_A,
                SPR_END_PIXEL_B: end_of_scan_r <= pixel_read_pointer_last;
                default: end_of_scan_r <= 1'b0;
            endcase
        end
    end

    // One-hot route: bit 0 pixel, 1 temperature, 2..5 aux inputs 1..4
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            analog_route_r <= '0;
        end else begin
            case (ain_sel)
                SPR_AIN_PIXEL: analog_route_r <= 6'h01;
                SPR_AIN_TEMP: analog_route_r <= 6'h02;
                SPR_AIN_AUX1: analog_route_r <= 6'h04;
                SPR_AIN_AUX2: analog_route_r <= 6'h08;
                SPR_AIN_AUX3: analog_route_r <= 6'h10;
                SPR_AIN_AUX4: analog_route_r <= 6'h20;
                default: analog_route_r <= 6'h00; // Unused codes route nothing
            endcase
        end
    end

    // Power enables follow standby; all off while in standby
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            column_bias_en_r <= 1'b1;
            amp_en_r <= 1'b1;
            out_buffer_en_r <= 1'b1;
            offset_dac_en_r <= 1'b1;
        end else begin
            column_bias_en_r <= !standby;
            amp_en_r <= !standby;
            out_buffer_en_r <= !standby;
            offset_dac_en_r <= !standby;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Amplifier, black level and column offset controls

    assign amp_offset_code = output_amp_setting[SPR_AOFS_HI:SPR_AOFS_LO];
    assign amp_gain_code = output_amp_setting[SPR_GAIN_HI:SPR_GAIN_LO];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            amp_gain_factor_r <= 4'h1;
        end else begin
            amp_gain_factor_r <= 4'(4'h1 << amp_gain_code);
        end
    end

    // Black level steps: signed 10 mV step count from mid-scale
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            black_level_apply_r <= 1'b0;
            column_offset_apply_r <= 1'b1;
            black_level_steps_r <= '0;
        end else begin
            black_level_apply_r <= readout_mode_bit;
            column_offset_apply_r <= !readout_mode_bit;
            if (ndr_black_level[SPR_BLACK_SIGN_BIT]) begin
                black_level_steps_r <= $signed({1'b1, ndr_black_level});
            end else begin
                black_level_steps_r <= $signed({1'b0, ndr_black_level});
            end
        end
    end

endmodule

/* bench/spr_ctrl_model.sv */
/*
 * Controller model: drives the programming bus and the three load strobes.
 * Assumes clk_sys from the bench; changes only at falling edges.
 */
`timescale 1ns/10ps
module spr_ctrl_model
    import spr_pkg::*;
(
    input wire logic clk_sys,
    output logic [SPR_BUS_W-1:0] prog_bus,
    output logic column_start_strobe,
    output logic line_start_strobe,
    output logic mode_load_strobe
);
    initial begin
        prog_bus = 10'h000;
        column_start_strobe = 1'b0;
        line_start_strobe = 1'b0;
        mode_load_strobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Kind 0 column, 1 line, 2 mode; setup, width and hold of 100 ns each
    task automatic load(input int kind, input logic [SPR_BUS_W-1:0] v);
        @(negedge clk_sys);
        prog_bus = v;
        repeat (4) @(negedge clk_sys);
        column_start_strobe = (kind == 0);
        line_start_strobe = (kind == 1);
        mode_load_strobe = (kind == 2);
        repeat (4) @(negedge clk_sys);
        column_start_strobe = 1'b0;
        line_start_strobe = 1'b0;
        mode_load_strobe = 1'b0;
        repeat (4) @(negedge clk_sys);
        // Stale bus must not leak into any register
        prog_bus = ~v;
    endtask
endmodule

/* bench/spr_top_assertions.sv */
/*
 * Checker for spr_top port relations; bound into every spr_top.
 * Assumes one clock domain, clk_sys, with resetn synchronous active low.
 */
`timescale 1ns/10ps
module spr_top_assertions
    import spr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [SPR_BUS_W-1:0] prog_bus,
    input wire logic line_start_strobe,
    input wire logic column_start_strobe,
    input wire logic mode_load_strobe,
    input wire logic mode_reset_n,
    input wire logic pixel_read_pointer_last,
    input wire logic [SPR_BUS_W-1:0] line_start_coord,
    input wire logic [SPR_BUS_W-1:0] line_read_pointer_start,
    input wire logic [SPR_BUS_W-1:0] line_reset_pointer_start,
    input wire logic [SPR_BUS_W-1:0] column_start_coord,
    input wire logic [SPR_BUS_W-1:0] pixel_read_pointer_start,
    input wire logic [SPR_REG_W-1:0] scan_mode_control,
    input wire logic [SPR_REG_W-1:0] output_amp_setting,
    input wire logic [SPR_REG_W-1:0] ndr_black_level,
    input wire logic [SPR_REG_W-1:0] column_offset_trim,
    input wire logic end_of_scan_r,
    input wire logic column_bias_en_r,
    input wire logic amp_en_r,
    input wire logic out_buffer_en_r,
    input wire logic offset_dac_en_r,
    input wire logic [3:0] amp_gain_factor_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    a_line_follow: assert property (line_start_strobe |=>
        line_start_coord == $past(prog_bus)) else $error("line start missed the bus");
    a_col_follow: assert property (column_start_strobe |=>
        column_start_coord == $past(prog_bus)) else $error("column start missed the bus");
    a_line_hold: assert property (!line_start_strobe |=> $stable(line_start_coord))
        else $error("line start changed without strobe");
    a_pointer_seed: assert property (line_read_pointer_start == line_start_coord
        && line_reset_pointer_start == line_start_coord
        && pixel_read_pointer_start == column_start_coord) else $error("pointer seed mismatch");
    a_amp_write: assert property ($rose(mode_load_strobe) && mode_reset_n
        && prog_bus[9:8] == SPR_SEL_AMP |=> output_amp_setting == $past(prog_bus[7:0]))
        else $error("amplifier register not written");
    // Skip the first edge after reset: a strobe held through reset counts
    a_mode_hold: assert property (!$rose(mode_load_strobe) && mode_reset_n && $past(resetn)
        |=> $stable(scan_mode_control) && $stable(output_amp_setting))
        else $error("mode register changed without edge");
    a_mode_clear: assert property (!mode_reset_n |=> scan_mode_control == SPR_MODE_RST
        && output_amp_setting == SPR_MODE_RST && ndr_black_level == SPR_MODE_RST
        && column_offset_trim == SPR_MODE_RST) else $error("mode clear ignored");
    a_standby_gate: assert property (1'b1 |=> {column_bias_en_r, amp_en_r, out_buffer_en_r,
        offset_dac_en_r} == {4{!$past(scan_mode_control[0])}}) else $error("standby enables wrong");
    a_gain_decode: assert property (1'b1 |=>
        amp_gain_factor_r == (4'h1 << $past(output_amp_setting[1:0])))
        else $error("gain factor wrong");
    a_scan_end_pixel: assert property (scan_mode_control[6] |=>
        end_of_scan_r == $past(pixel_read_pointer_last)) else $error("end of scan not pixel");
endmodule

bind spr_top spr_top_assertions u_chk (.*);

/* bench/sensor_parallel_register_load_tb.sv */
/*
 * Self-checking bench for spr_top, driven through the controller model.
 * Assumes spr_pkg, the design and the checker are compiled first.
 */
`timescale 1ns/10ps
module sensor_parallel_register_load_tb
    import spr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic mode_reset_n = 1'b1;
    logic line_read_pointer_last = 1'b0;
    logic line_reset_pointer_last = 1'b0;
    logic pixel_read_pointer_last = 1'b0;
    logic [SPR_BUS_W-1:0] prog_bus, line_start_coord, line_read_pointer_start;
    logic [SPR_BUS_W-1:0] line_reset_pointer_start, column_start_coord, pixel_read_pointer_start;
    logic [SPR_REG_W-1:0] scan_mode_control, output_amp_setting, ndr_black_level;
    logic [SPR_REG_W-1:0] column_offset_trim;
    logic column_start_strobe, line_start_strobe, mode_load_strobe, end_of_scan_r;
    logic readout_mode_bit, column_bias_en_r, amp_en_r, out_buffer_en_r, offset_dac_en_r;
    logic black_level_apply_r, column_offset_apply_r;
    logic [SPR_AIN_OUTS-1:0] analog_route_r;
    logic [5:0] amp_offset_code;
    logic [1:0] amp_gain_code;
    logic [3:0] amp_gain_factor_r;
    logic signed [SPR_REG_W:0] black_level_steps_r;
    int err_total = 0;
    int checks = 0;
    logic [31:0] lfsr = 32'h03273589;
    logic [SPR_BUS_W-1:0] exp_line = 10'h000;
    logic [SPR_BUS_W-1:0] exp_col = 10'h000;
    logic [SPR_REG_W-1:0] exp_r [SPR_NUM_REGS];

    always #12.5 clk_sys = ~clk_sys;

    spr_top dut (.*);
    spr_ctrl_model ctl (.*);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [5:0] route_of(input logic [2:0] a);
        if (a[2]) return 6'h04 << a[1:0];
        return (a == 3'h0) ? 6'h01 : (a == 3'h1) ? 6'h02 : 6'h00;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check_all();
        check(line_start_coord, exp_line);
        check(line_read_pointer_start, exp_line);
        check(line_reset_pointer_start, exp_line);
        check(pixel_read_pointer_start, exp_col);
        check(column_start_coord, exp_col);
        check(scan_mode_control, exp_r[0]);
        check(output_amp_setting, exp_r[1]);
        check(ndr_black_level, exp_r[2]);
        check(column_offset_trim, exp_r[3]);
        check(end_of_scan_r, exp_r[0][6] ? pixel_read_pointer_last :
            exp_r[0][5] ? line_reset_pointer_last : line_read_pointer_last);
        check(analog_route_r, route_of(exp_r[0][4:2]));
        check(readout_mode_bit, exp_r[0][1]);
        check({column_bias_en_r, amp_en_r, out_buffer_en_r, offset_dac_en_r},
            {4{!exp_r[0][0]}});
        check({amp_offset_code, amp_gain_code}, exp_r[1]);
        check(amp_gain_factor_r, 4'h1 << exp_r[1][1:0]);
        check(black_level_apply_r, exp_r[0][1]);
        check(column_offset_apply_r, !exp_r[0][1]);
        check($unsigned(black_level_steps_r), {exp_r[2][SPR_BLACK_SIGN_BIT], exp_r[2]});
    endtask

    task automatic put(input int kind, input logic [SPR_BUS_W-1:0] v);
        lfsr = next_rand(lfsr);
        {line_read_pointer_last, line_reset_pointer_last, pixel_read_pointer_last} = lfsr[2:0];
        ctl.load(kind, v);
        if (kind == 0) exp_col = v;
        else if (kind == 1) exp_line = v;
        else if (mode_reset_n) exp_r[v[9:8]] = v[7:0];
        repeat (2) @(negedge clk_sys);
        check_all();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        err_total++;
        summarize();
    end

    initial begin
        for (int i = 0; i < SPR_NUM_REGS; i++) exp_r[i] = SPR_MODE_RST;
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        check_all();
        $display("test reset values done");
        put(2, {SPR_SEL_AMP, 6'd60, 2'b00});
        for (int i = 0; i < 8; i++) begin
            put(2, {SPR_SEL_SCAN, 1'b0, i[1:0], i[2:0], i[1], i[0]});
            put(2, {SPR_SEL_AMP, 6'(i * 9), i[1:0]});
            put(2, {SPR_SEL_BLACK, 8'(i * 37)});
            put(2, {SPR_SEL_COLOFS, 8'(i * 29)});
        end
        $display("test select and field codes done");
        put(0, 10'h3FF);
        put(1, 10'h3FF);
        put(1, 10'h000);
        $display("test coordinate bounds done");
        mode_reset_n = 1'b0;
        for (int i = 0; i < SPR_NUM_REGS; i++) exp_r[i] = SPR_MODE_RST;
        put(2, {SPR_SEL_BLACK, 8'h5A});
        mode_reset_n = 1'b1;
        $display("test mode clear done");
        for (int i = 0; i < 40; i++) begin
            lfsr = next_rand(lfsr);
            put((lfsr[1:0] == 2'h3) ? 2 : int'(lfsr[1:0]), lfsr[13:4]);
        end
        $display("test random loads done");
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        exp_line = SPR_COORD_RST;
        exp_col = SPR_COORD_RST;
        for (int i = 0; i < SPR_NUM_REGS; i++) exp_r[i] = SPR_MODE_RST;
        repeat (3) @(negedge clk_sys);
        check_all();
        put(1, 10'h155);
        put(2, {SPR_SEL_SCAN, 8'h41});
        $display("test second reset done");
        summarize();
    end
endmodule
